// >>> logic/ext_bus_cfg.svh
// timing counts, reset values and field positions for the external bus pin block
// assumes inclusion by bare name; definitions only
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH
`define OSC_PER_MCYCLE     4
`define RST_QUAL_MCYCLES   2
`define P1_T2_COUNT        0
`define P1_T2_AUX          1
`define P1_SER2_RX         2
`define P1_SER2_TX         3
`define P1_IRQ_LO          4
`define P3_SER1_RX         0
`define P3_SER1_TX         1
`define P3_IRQ0            2
`define P3_IRQ1            3
`define P3_T0              4
`define P3_T1              5
`define P3_WR_STROBE       6
`define P3_RD_STROBE       7
`define P4_WAIT            0
`define P4_REBOOT          3
`define PORT_RESET_VAL     8'hFF
`endif

// >>> logic/ext_bus_pkg.sv
// types for the external bus pin block
// assumes ext_bus_cfg.svh carries the numeric constants
package ext_bus_pkg;
   typedef enum logic [1:0] {
      acc_idle,
      acc_code,
      acc_rd,
      acc_wr
   } acc_kind_e;
   // core request toward the external bus
   typedef struct packed {
      logic       valid;
      acc_kind_e  kind;
      logic [15:0] addr;
      logic [7:0] wdata;
   } bus_req_s;
   // alternate-function inputs handed to the core peripherals
   typedef struct packed {
      logic       timer_two_count_input;
      logic       timer_two_aux_control;
      logic       second_serial_receive;
      logic       first_serial_receive;
      logic       timer_zero_input;
      logic       timer_one_input;
      logic [5:0] ext_irq;
      logic       wait_in;
      logic       reboot_req;
   } alt_in_s;
   typedef enum logic [2:0] {
      ph_idle,
      ph_addr,
      ph_latch,
      ph_data,
      ph_stretch,
      ph_done
   } phase_e;
endpackage

// >>> logic/ext_bus_pins.sv
// external memory bus sequencer, port multiplexing and reset qualification
// assumes pins pass through pads resolving output enables; core runs on clk
`timescale 1ns/1ns
`include "ext_bus_cfg.svh"
module ext_bus_pins #(
   parameter int MC_LEN  = `OSC_PER_MCYCLE,
   parameter int RST_MCS = `RST_QUAL_MCYCLES
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // core side
   input  wire ext_bus_pkg::bus_req_s req,
   input  wire logic                  code_is_internal,
   input  wire logic [7:0]            p0_gpio,
   input  wire logic [7:0]            p1_gpio,
   input  wire logic [7:0]            p2_gpio,
   input  wire logic [7:0]            p3_gpio,
   input  wire logic [3:0]            p4_gpio,
   input  wire logic                  p0_pullup_en,
   input  wire logic                  wait_enable,
   input  wire logic                  second_serial_transmit,
   input  wire logic                  first_serial_transmit,
   output logic                       req_done,
   output logic [7:0]                 rdata,
   output logic                       core_reset,
   output logic                       fetch_external,
   output ext_bus_pkg::alt_in_s       alt_in,
   // strap and pins
   input  wire logic                  external_fetch_select_n,
   input  wire logic                  rst_pin,
   input  wire logic [7:0]            p0_in,
   input  wire logic [7:0]            p1_in,
   input  wire logic [7:0]            p3_in,
   input  wire logic [3:0]            p4_in,
   output logic [7:0]                 p0_out,
   output logic [7:0]                 p0_oe,
   output logic                       p0_pullup,
   output logic [7:0]                 p1_out,
   output logic [7:0]                 p2_out,
   output logic [7:0]                 p3_out,
   output logic [3:0]                 p4_out,
   output logic [3:0]                 p4_oe,
   output logic                       program_fetch_strobe_n,
   output logic                       addr_latch_strobe
);
   localparam int RST_CLKS = MC_LEN * RST_MCS;

   typedef struct packed {
      logic [7:0]           s1_p0, s2_p0;
      logic [7:0]           s1_p1, s2_p1;
      logic [7:0]           s1_p3, s2_p3;
      logic [3:0]           s1_p4, s2_p4;
      logic [1:0]           s1_misc, s2_misc;
      logic [3:0]           rst_cnt;
      logic [1:0]           settle;
      logic                 core_reset;
      logic                 fetch_external;
      logic [1:0]           mc_cnt;
      ext_bus_pkg::phase_e  ph;
      ext_bus_pkg::acc_kind_e kind;
      logic [15:0]          addr;
      logic [7:0]           wdata;
      logic                 req_done;
      logic [7:0]           rdata;
      logic [7:0]           p0_out, p0_oe;
      logic                 p0_pullup;
      logic [7:0]           p1_out, p2_out, p3_out;
      logic [3:0]           p4_out, p4_oe;
      logic                 program_fetch_strobe_n_n;
      logic                 ale;
      ext_bus_pkg::alt_in_s alt;
   } state_s;

   state_s st;
   state_s next_st;
   logic   mc_tick;
   logic   wait_seen;

   assign mc_tick   = (st.mc_cnt == 2'(MC_LEN - 1));
   assign wait_seen = wait_enable & ~st.s2_p4[`P4_WAIT];

   // next-state logic for the whole block
   always_comb begin
      next_st = st;
      // two-stage synchronisers on every pin input
      next_st.s1_p0 = p0_in;
      next_st.s2_p0 = st.s1_p0;
      next_st.s1_p1 = p1_in;
      next_st.s2_p1 = st.s1_p1;
      next_st.s1_p3 = p3_in;
      next_st.s2_p3 = st.s1_p3;
      next_st.s1_p4 = p4_in;
      next_st.s2_p4 = st.s1_p4;
      next_st.s1_misc = {rst_pin, external_fetch_select_n};
      next_st.s2_misc = st.s1_misc;
      next_st.mc_cnt = st.mc_cnt + 2'h1;
      next_st.req_done = 1'b0;
      // reset pin must stay high a full qualification window;
      // core reset is held until the strap has crossed both synchroniser stages,
      // otherwise the cleared synchroniser would be taken for a low strap
      next_st.settle = {st.settle[0], 1'b1};
      if (!st.s2_misc[1]) begin
         next_st.rst_cnt = 4'h0;
         next_st.core_reset = ~st.settle[1];
      end else if (st.rst_cnt >= 4'(RST_CLKS - 1)) begin
         next_st.core_reset = 1'b1;
      end else begin
         next_st.rst_cnt = st.rst_cnt + 4'h1;
      end
      // strap sampled while reset held, so it stays stable during a run
      if (st.core_reset) begin
         next_st.fetch_external = ~st.s2_misc[0];
      end
      // bus sequencer, one phase per machine cycle
      if (mc_tick) begin
         case (st.ph)
            ext_bus_pkg::ph_idle: begin
               if (req.valid && !st.core_reset
                   && !(req.kind == ext_bus_pkg::acc_code && code_is_internal && !st.fetch_external)) begin
                  next_st.ph    = ext_bus_pkg::ph_addr;
                  next_st.kind  = req.kind;
                  next_st.addr  = req.addr;
                  next_st.wdata = req.wdata;
                  next_st.ale   = 1'b1;
               end
            end
            ext_bus_pkg::ph_addr: begin
               next_st.ale = 1'b0;
               next_st.ph  = ext_bus_pkg::ph_data;
               if (st.kind == ext_bus_pkg::acc_code) begin
                  next_st.program_fetch_strobe_n_n = 1'b0;
               end
            end
            ext_bus_pkg::ph_data: begin
               next_st.ph = wait_seen ? ext_bus_pkg::ph_stretch : ext_bus_pkg::ph_done;
            end
            ext_bus_pkg::ph_stretch: begin
               if (!wait_seen) begin
                  next_st.ph = ext_bus_pkg::ph_done;
               end
            end
            ext_bus_pkg::ph_done: begin
               next_st.rdata    = st.s2_p0;
               next_st.req_done = 1'b1;
               next_st.program_fetch_strobe_n_n   = 1'b1;
               next_st.ph       = ext_bus_pkg::ph_idle;
            end
            default: next_st.ph = ext_bus_pkg::ph_idle;
         endcase
      end
      // reset aborts any access before the port drive below can show it
      if (st.core_reset) begin
         next_st.ph     = ext_bus_pkg::ph_idle;
         next_st.program_fetch_strobe_n_n = 1'b1;
         next_st.ale    = 1'b0;
      end
      // port drive: address phase, then data or release
      next_st.p0_pullup = p0_pullup_en;
      next_st.p2_out = p2_gpio;
      next_st.p0_out = p0_gpio;
      next_st.p0_oe  = ~p0_gpio; // open-drain pulls low only
      next_st.p3_out = p3_gpio;
      next_st.p3_out[`P3_SER1_TX] = p3_gpio[`P3_SER1_TX] & first_serial_transmit;
      next_st.p1_out = p1_gpio;
      next_st.p1_out[`P1_SER2_TX] = p1_gpio[`P1_SER2_TX] & second_serial_transmit;
      if (next_st.ph != ext_bus_pkg::ph_idle) begin
         next_st.p2_out = next_st.addr[15:8];
         if (next_st.ph == ext_bus_pkg::ph_addr) begin
            next_st.p0_out = next_st.addr[7:0];
            next_st.p0_oe  = 8'hFF;
         end else if (next_st.kind == ext_bus_pkg::acc_wr) begin
            next_st.p0_out = next_st.wdata;
            next_st.p0_oe  = 8'hFF;
            next_st.p3_out[`P3_WR_STROBE] = 1'b0;
         end else begin
            next_st.p0_oe = 8'h00;
            if (next_st.kind == ext_bus_pkg::acc_rd) begin
               next_st.p3_out[`P3_RD_STROBE] = 1'b0;
            end
         end
      end
      // port 4 quasi-bidirectional, wait pin released when enabled
      next_st.p4_out = p4_gpio;
      next_st.p4_oe  = ~p4_gpio;
      if (wait_enable) begin
         next_st.p4_oe[`P4_WAIT] = 1'b0;
      end
      // alternate-function input routing
      next_st.alt.timer_two_count_input = st.s2_p1[`P1_T2_COUNT];
      next_st.alt.timer_two_aux_control = st.s2_p1[`P1_T2_AUX];
      next_st.alt.second_serial_receive = st.s2_p1[`P1_SER2_RX];
      next_st.alt.first_serial_receive  = st.s2_p3[`P3_SER1_RX];
      next_st.alt.timer_zero_input      = st.s2_p3[`P3_T0];
      next_st.alt.timer_one_input       = st.s2_p3[`P3_T1];
      next_st.alt.ext_irq = {st.s2_p1[7:`P1_IRQ_LO], st.s2_p3[`P3_IRQ1], st.s2_p3[`P3_IRQ0]};
      next_st.alt.wait_in    = wait_seen;
      next_st.alt.reboot_req = ~st.s2_p4[`P4_REBOOT];
   end

   // single state register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
         st.ph <= ext_bus_pkg::ph_idle;
         st.kind <= ext_bus_pkg::acc_idle;
         st.program_fetch_strobe_n_n <= 1'b1;
         st.core_reset <= 1'b1;
         st.p1_out <= `PORT_RESET_VAL;
         st.p2_out <= `PORT_RESET_VAL;
         st.p3_out <= `PORT_RESET_VAL;
         st.p4_out <= 4'hF;
      end else begin
         st <= next_st;
      end
   end

   assign req_done               = st.req_done;
   assign rdata                  = st.rdata;
   assign core_reset             = st.core_reset;
   assign fetch_external         = st.fetch_external;
   assign alt_in                 = st.alt;
   assign p0_out                 = st.p0_out;
   assign p0_oe                  = st.p0_oe;
   assign p0_pullup              = st.p0_pullup;
   assign p1_out                 = st.p1_out;
   assign p2_out                 = st.p2_out;
   assign p3_out                 = st.p3_out;
   assign p4_out                 = st.p4_out;
   assign p4_oe                  = st.p4_oe;
   assign program_fetch_strobe_n = st.program_fetch_strobe_n_n;
   assign addr_latch_strobe      = st.ale;

   // checks
   a_program_fetch_strobe_n_code_only: assert property (@(posedge clk) disable iff (sys_rst)
      !program_fetch_strobe_n |-> st.kind == ext_bus_pkg::acc_code) else $error("fetch strobe on non-code access");
   a_program_fetch_strobe_n_ext: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(program_fetch_strobe_n) |-> $past(st.kind) == ext_bus_pkg::acc_code) else $error("strobe without code");
   a_ale_pulse: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(addr_latch_strobe) |-> addr_latch_strobe [*4] ##1 !addr_latch_strobe) else $error("latch strobe width");
   a_ale_addr: assert property (@(posedge clk) disable iff (sys_rst)
      addr_latch_strobe |-> p0_oe == 8'hFF && p0_out == st.addr[7:0]) else $error("low address missing");
   a_p2_addr: assert property (@(posedge clk) disable iff (sys_rst)
      addr_latch_strobe |-> p2_out == st.addr[15:8]) else $error("upper address missing");
   a_wr_strobe: assert property (@(posedge clk) disable iff (sys_rst)
      !p3_out[`P3_WR_STROBE] && !p3_gpio[`P3_WR_STROBE] == 1'b0 |-> st.kind == ext_bus_pkg::acc_wr)
      else $error("write strobe misuse");
   a_rd_strobe: assert property (@(posedge clk) disable iff (sys_rst)
      !p3_out[`P3_RD_STROBE] && p3_gpio[`P3_RD_STROBE] |-> st.kind == ext_bus_pkg::acc_rd)
      else $error("read strobe misuse");
   a_wait_input: assert property (@(posedge clk) disable iff (sys_rst)
      $past(wait_enable) |-> !p4_oe[`P4_WAIT]) else $error("wait pin driven");
   a_rst_qual: assert property (@(posedge clk) disable iff (sys_rst)
      !core_reset && !st.s2_misc[1] ##1 st.s2_misc[1] [*7] |-> !core_reset) else $error("reset too early");
   c_code_fetch: cover property (@(posedge clk) $fell(program_fetch_strobe_n));
   c_write: cover property (@(posedge clk) $fell(p3_out[`P3_WR_STROBE]));
   c_stretch: cover property (@(posedge clk) st.ph == ext_bus_pkg::ph_stretch);
endmodule // ext_bus_pins

// >>> verif/ext_mem_model.sv
// behavioural external rom, data memory and low address latch
// assumes the pin block's registered strobes; resolves the port 0 wire
`timescale 1ns/1ns
module ext_mem_model (
   // clock
   input  wire logic       clk,
   // pins from the block
   input  wire logic       ale,
   input  wire logic       program_fetch_strobe_n_n,
   input  wire logic       wr_n,
   input  wire logic       rd_n,
   input  wire logic [7:0] p0_out,
   input  wire logic [7:0] p0_oe,
   input  wire logic [7:0] p2_out,
   // resolved port 0 wire
   output logic [7:0]      p0_in
);
   logic [7:0]     addr_lo = 8'h00;
   logic [7:0]     mem [0:65535];
   logic [0:65535] written = '0;
   logic [15:0]    a;
   logic [7:0]     dv;
   assign a = {p2_out, addr_lo};
   // unwritten places read as a pattern that depends on both address bytes
   assign dv = written[a] ? mem[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
   // keep the last low byte seen while the latch strobe is high
   always @(posedge clk) begin
      if (ale) addr_lo <= p0_out;
      if (!wr_n) begin
         mem[a] <= p0_out;
         written[a] <= 1'b1;
      end
   end
   // answer while a read strobe is low; released lines show the inverse, never a stale value
   always @* begin
      for (int i = 0; i < 8; i++) begin
         if (p0_oe[i]) p0_in[i] = p0_out[i];
         else p0_in[i] = (!program_fetch_strobe_n_n || !rd_n) ? dv[i] : ~dv[i];
      end
   end
endmodule // ext_mem_model

// >>> verif/tb_top.sv
// self-checking bench for the external bus pin block
// assumes ext_mem_model stands on port 0 and port 2; bench drives 5 ns after each rising edge
`timescale 1ns/1ns
module tb_top;
   logic                  clk = 0, sys_rst = 1, rst_pin = 0, external_fetch_select_n = 0;
   logic                  code_is_internal = 0, p0_pullup_en = 0, wait_enable = 1, sst = 1, fst = 1;
   logic [7:0]            p0_gpio = 8'hFF, p1_gpio = 8'hFF, p2_gpio = 8'h3C, p3_gpio = 8'hFF;
   logic [7:0]            p1_in = 8'hFF, p3_in = 8'hFF, p0_in, p0_out, p0_oe, p1_out, p2_out, p3_out, rdata;
   logic [3:0]            p4_gpio = 4'hF, p4_in = 4'hF, p4_out, p4_oe;
   logic                  req_done, core_reset, fetch_external, p0_pullup, program_fetch_strobe_n_n, ale;
   logic                  saw_program_fetch_strobe_n, saw_wr, saw_rd;
   int                    ale_len, n_errors = 0, cmp_count = 0, lat1, lat2;
   ext_bus_pkg::bus_req_s req = '0;
   ext_bus_pkg::alt_in_s  exp_alt, alt_in;
   always #25 clk = ~clk;
   ext_bus_pins i_ext_bus_pins (.clk(clk), .sys_rst(sys_rst), .req(req), .code_is_internal(code_is_internal),
      .p0_gpio(p0_gpio), .p1_gpio(p1_gpio), .p2_gpio(p2_gpio), .p3_gpio(p3_gpio), .p4_gpio(p4_gpio),
      .p0_pullup_en(p0_pullup_en), .wait_enable(wait_enable), .second_serial_transmit(sst),
      .first_serial_transmit(fst), .req_done(req_done), .rdata(rdata), .core_reset(core_reset),
      .fetch_external(fetch_external), .alt_in(alt_in), .external_fetch_select_n(external_fetch_select_n),
      .rst_pin(rst_pin), .p0_in(p0_in), .p1_in(p1_in), .p3_in(p3_in), .p4_in(p4_in), .p0_out(p0_out),
      .p0_oe(p0_oe), .p0_pullup(p0_pullup), .p1_out(p1_out), .p2_out(p2_out), .p3_out(p3_out),
      .p4_out(p4_out), .p4_oe(p4_oe), .program_fetch_strobe_n(program_fetch_strobe_n_n), .addr_latch_strobe(ale));
   ext_mem_model i_ext_mem_model (.clk(clk), .ale(ale), .program_fetch_strobe_n_n(program_fetch_strobe_n_n), .wr_n(p3_out[6]), .rd_n(p3_out[7]),
      .p0_out(p0_out), .p0_oe(p0_oe), .p2_out(p2_out), .p0_in(p0_in));
   // strobe watchers, cleared at the start of each access
   always @(posedge clk) begin
      if (!program_fetch_strobe_n_n) saw_program_fetch_strobe_n <= 1;
      if (!p3_out[6]) saw_wr <= 1;
      if (!p3_out[7]) saw_rd <= 1;
      if (ale) ale_len <= ale_len + 1;
   end
   task automatic complete_run;
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task automatic hang(input string m);
      check(0, 1, m);
      complete_run;
   endtask
   task automatic access(input ext_bus_pkg::acc_kind_e k, input logic [15:0] ad, input logic [7:0] wd,
                         output int lat);
      saw_program_fetch_strobe_n = 0; saw_wr = 0; saw_rd = 0; ale_len = 0; lat = 0;
      req = '{1'b1, k, ad, wd};
      // pass an edge first: the done pulse of a previous access still stands here
      do begin
         @(posedge clk);
         #5 lat++;
         if (lat > 200) hang("access hang");
      end while (req_done !== 1'b1);
      req.valid = 0;
   endtask
   task automatic do_reset(input logic sel_n);
      sys_rst = 1; external_fetch_select_n = sel_n;
      repeat (8) @(posedge clk);
      #5 sys_rst = 0;
      for (int i = 0; core_reset !== 1'b0; i++) begin
         if (i > 60) hang("reset hang");
         @(posedge clk);
         #5;
      end
      check(fetch_external, !sel_n, "fetch select");
   endtask
   // code fetch forced external although the core calls it internal
   task automatic sc_code;
      code_is_internal = 1;
      access(ext_bus_pkg::acc_code, 16'h12C4, 8'h00, lat1);
      check(rdata, 8'h12 ^ 8'hC4 ^ 8'h5A, "code data");
      check({saw_program_fetch_strobe_n, saw_rd, saw_wr}, 3'b100, "code strobes");
      check(ale_len, 4, "latch strobe width");
      check(lat1 >= 12, 1, "access too short");
      code_is_internal = 0;
   endtask
   // write then read back, a read of an unwritten place, then a read stretched by the wait pin
   task automatic sc_data;
      access(ext_bus_pkg::acc_wr, 16'h0A31, 8'hC3, lat1);
      check({saw_program_fetch_strobe_n, saw_rd, saw_wr}, 3'b001, "write strobes");
      access(ext_bus_pkg::acc_rd, 16'h0A31, 8'h00, lat1);
      check(rdata, 8'hC3, "read back");
      check({saw_program_fetch_strobe_n, saw_rd, saw_wr}, 3'b010, "read strobes");
      access(ext_bus_pkg::acc_rd, 16'h5E00, 8'h00, lat1);
      check(rdata, 8'h5E ^ 8'h5A, "upper address");
      p4_in[0] = 0;
      fork
         begin
            repeat (20) @(posedge clk);
            #5 p4_in[0] = 1;
         end
      join_none
      access(ext_bus_pkg::acc_rd, 16'h0A31, 8'h00, lat2);
      check(lat2 > lat1 + 8, 1, "no stretch");
      check(rdata, 8'hC3, "stretched read");
   endtask
   // alternate inputs routed for two opposite patterns, tx gating and port 0 drive
   task automatic sc_alt;
      logic [7:0] v;
      logic [7:0] w;
      p4_gpio = 4'h0; sst = 0; fst = 0; p0_gpio = 8'h0F;
      for (int b = 0; b < 2; b++) begin
         v = b ? 8'hA5 : 8'h5A;
         w = ~v;
         p1_in = v; p3_in = w; p4_in = {v[3], 2'b11, v[0]};
         repeat (5) @(posedge clk);
         #5 exp_alt = '{v[0], v[1], v[2], w[0], w[4], w[5], {v[7:4], w[3], w[2]}, ~v[0], ~v[3]};
         check(alt_in, exp_alt, "alt routing");
         check({p4_out, p4_oe}, 8'h0E, "wait pin driven");
         check({p1_out, p3_out}, 16'hF7FD, "tx gating");
         check({p0_out, p0_oe}, 16'h0FF0, "port 0 open drain");
      end
      sst = 1; fst = 1; p0_gpio = 8'hFF; p1_in = 8'hFF; p3_in = 8'hFF; p4_in = 4'hF;
      // port 4 latch stays low so the wait pin drive shows once the function is off
      for (int b = 1; b >= 0; b--) begin
         p0_pullup_en = b[0];
         wait_enable = b[0];
         repeat (3) @(posedge clk);
         #5 check({p0_pullup, p4_oe[0]}, {b[0], !b[0]}, "pull-up or wait pin drive");
      end
      p4_gpio = 4'hF; wait_enable = 1;
   endtask
   // one machine cycle high is ignored, a long pulse resets
   task automatic sc_rst_pin;
      rst_pin = 1;
      repeat (4) @(posedge clk);
      #5 rst_pin = 0;
      repeat (16) begin
         @(posedge clk);
         #5 check(core_reset, 0, "short reset taken");
      end
      rst_pin = 1;
      repeat (24) @(posedge clk);
      #5 check(core_reset, 1, "reset missed");
      rst_pin = 0;
      repeat (8) @(posedge clk);
      #5 check(core_reset, 0, "reset stuck");
   endtask
   // internal code fetch with the select high never reaches the pins
   task automatic sc_internal;
      saw_program_fetch_strobe_n = 0; ale_len = 0; code_is_internal = 1;
      req = '{1'b1, ext_bus_pkg::acc_code, 16'h0040, 8'h00};
      repeat (40) begin
         @(posedge clk);
         #5 check(req_done, 0, "internal fetch answered");
      end
      check({saw_program_fetch_strobe_n, ale_len != 0}, 2'b00, "internal strobes");
      check(p2_out, p2_gpio, "internal address on port 2");
      req.valid = 0; code_is_internal = 0;
      @(posedge clk);
      #5 access(ext_bus_pkg::acc_code, 16'hF00D, 8'h00, lat1);
      check({saw_program_fetch_strobe_n, rdata}, {1'b1, 8'hF0 ^ 8'h0D ^ 8'h5A}, "external code");
   endtask
   initial begin
      do_reset(0);
      sc_code;
      sc_data;
      sc_alt;
      sc_rst_pin;
      do_reset(1);
      sc_internal;
      complete_run;
   end
endmodule // tb_top
